//--- src/ttc_control.v
// Timer three: control register, sixteen-bit or split counter, reload and capture logic.
//
// Functional notes
// [R1] The control register sits at address 0x91 on page 0x0 with flags, enables, split, run and clock select from bit 7 down.
// [R2] The high overflow flag is set whenever the upper byte rolls from 0xFF to 0x00.
// [R3] In sixteen-bit operation the high flag is set when the whole count wraps from 0xFFFF to 0x0000, and also by each capture trigger in capture mode.
// [R4] A set high overflow flag raises the interrupt request when the timer interrupt is enabled.
// [R5] The low overflow flag is set whenever the lower byte rolls from 0xFF to 0x00 in any mode.
// [R6] Hardware never clears either overflow flag; software clears them.
// [R7] With the low interrupt enable set, a lower byte overflow also raises the interrupt request.
// [R8] With capture enable set the timer captures instead of reloading.
// [R9] With split select set the timer runs as two 8-bit counters each reloading from its own byte.
// [R10] With split select clear the timer is one 16-bit counter reloading from the reload pair.
// [R11] Run control starts and stops counting and in split mode gates only the upper byte.
// [R12] Clock select picks the external clock and capture trigger: 00 div12 and comparator, 01 osc/8 for both, 11 comparator and osc/8.
// [R13] In capture mode each trigger copies the count into the reload pair and sets the high flag.
// [R14] All control bits reset to zero and software writes set or clear every bit directly; a flag that hardware sets in the same cycle stays set.
`timescale 1ns/1ps
`include "ttc_consts.vh"

module ttc_control (
	input  wire       clk,
	input  wire       rstn,
	input  wire [7:0] sfr_page,
	input  wire [7:0] sfr_addr,
	input  wire       sfr_wr,
	input  wire       sfr_rd,
	input  wire [7:0] sfr_wdata,
	output wire [7:0] sfr_rdata,
	input  wire       timer_int_enable,
	input  wire       upper_sys_clock_sel,
	input  wire       lower_sys_clock_sel,
	input  wire       comparator_in,
	input  wire       ext_osc_in,
	output wire       irq
);

	reg  [7:0] ctrl_q;
	reg  [7:0] ctrl_d;
	reg  [7:0] rl_lo_q;
	reg  [7:0] rl_lo_d;
	reg  [7:0] rl_hi_q;
	reg  [7:0] rl_hi_d;
	reg  [7:0] cnt_lo_q;
	reg  [7:0] cnt_lo_d;
	reg  [7:0] cnt_hi_q;
	reg  [7:0] cnt_hi_d;
	reg  [7:0] rdata_q;
	reg  [3:0] div12_q;
	reg  [2:0] osc_cnt_q;
	reg        cmp_prev_q;
	reg        osc_prev_q;
	reg        ext_tick;
	reg        trig_tick;
	wire       cmp_s;
	wire       osc_s;
	wire       div12_tick;
	wire       cmp_rise;
	wire       osc_rise;
	wire       osc8_tick;
	wire       tick_lo;
	wire       tick_hi;
	wire       split;
	wire       capture;
	wire       run;
	wire       lo_inc;
	wire       lo_ovf;
	wire       hi_inc;
	wire       hi_ovf;
	wire       capt_ev;
	wire       page_ok;

	// Address decode shared by the write and read paths.
	function sel;
		input [7:0] addr;
		input [7:0] want;
		begin
			sel = (addr == want);
		end
	endfunction

	// Comparator and oscillator come from other clock domains.
	ttc_sync u_cmp_sync (
		.clk  (clk),
		.rstn (rstn),
		.din  (comparator_in),
		.dout (cmp_s)
	);

	ttc_sync u_osc_sync (
		.clk  (clk),
		.rstn (rstn),
		.din  (ext_osc_in),
		.dout (osc_s)
	);

	// Divide-by-twelve enable and edge counting of the synchronised inputs.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div12_q    <= 4'h0;
			osc_cnt_q  <= 3'h0;
			cmp_prev_q <= 1'b0;
			osc_prev_q <= 1'b0;
		end else begin
			div12_q    <= div12_tick ? 4'h0 : div12_q + 4'h1;
			cmp_prev_q <= cmp_s;
			osc_prev_q <= osc_s;
			if (osc_rise) begin
				osc_cnt_q <= osc_cnt_q + 3'h1;
			end
		end
	end

	// Counters are widened to the integer width of the divider constants before comparing.
	assign div12_tick = ({28'h000_0000, div12_q} == (`TTC_SYS_DIV - 1));
	assign cmp_rise   = cmp_s & ~cmp_prev_q;
	assign osc_rise   = osc_s & ~osc_prev_q;
	assign osc8_tick  = osc_rise & ({29'h0000_0000, osc_cnt_q} == (`TTC_OSC_DIV - 1));

	// Clock and trigger source choice; the reserved code yields no ticks at all.
	always @* begin
		case (ctrl_q[`TTC_BIT_CLKSEL_HI:`TTC_BIT_CLKSEL_LO])
			`TTC_CLKSEL_DIV12: begin
				ext_tick  = div12_tick; // R12
				trig_tick = cmp_rise;
			end
			`TTC_CLKSEL_OSC: begin
				ext_tick  = osc8_tick; // R12
				trig_tick = osc8_tick;
			end
			`TTC_CLKSEL_CMP: begin
				ext_tick  = cmp_rise; // R12
				trig_tick = osc8_tick;
			end
			default: begin
				ext_tick  = 1'b0;
				trig_tick = 1'b0;
			end
		endcase
	end

	assign tick_lo = lower_sys_clock_sel | ext_tick;
	assign tick_hi = upper_sys_clock_sel | ext_tick;
	assign split   = ctrl_q[`TTC_BIT_SPLIT];
	assign capture = ctrl_q[`TTC_BIT_CAPTURE];
	assign run     = ctrl_q[`TTC_BIT_RUN];

	// Split mode keeps the low byte running regardless of run control.
	assign lo_inc = split ? tick_lo : (run & tick_lo); // R11
	assign lo_ovf = lo_inc & (cnt_lo_q == `TTC_BYTE_MAX); // R5
	// In 16-bit mode the upper byte moves only on the carry out of the lower.
	assign hi_inc = split ? (run & tick_hi) : lo_ovf; // R9 R10 R11
	assign hi_ovf = hi_inc & (cnt_hi_q == `TTC_BYTE_MAX); // R2 R3
	assign capt_ev = capture & trig_tick; // R8
	assign page_ok = (sfr_page == `TTC_SFR_PAGE);

	// Next-state for counters, reload bytes and control; hardware sets win over software clears.
	always @* begin
		ctrl_d   = ctrl_q;
		rl_lo_d  = rl_lo_q;
		rl_hi_d  = rl_hi_q;
		cnt_lo_d = cnt_lo_q;
		cnt_hi_d = cnt_hi_q;
		// In 16-bit mode only the full wrap reloads; a lone low-byte roll carries and reads zero.
		if (lo_inc) begin
			if (lo_ovf && !capture && (split || hi_ovf)) begin
				cnt_lo_d = rl_lo_q; // R9 R10
			end else begin
				cnt_lo_d = cnt_lo_q + 8'h01;
			end
		end
		if (hi_inc) begin
			if (hi_ovf && !capture) begin
				cnt_hi_d = rl_hi_q; // R9 R10
			end else begin
				cnt_hi_d = cnt_hi_q + 8'h01;
			end
		end
		// Capture takes the count as it stood before this cycle's increment.
		if (capt_ev) begin
			rl_lo_d = cnt_lo_q; // R13
			rl_hi_d = cnt_hi_q;
		end
		if (sfr_wr && page_ok) begin
			if (sel(sfr_addr, `TTC_ADDR_CONTROL)) begin
				ctrl_d = sfr_wdata; // R1 R14
			end
			if (sel(sfr_addr, `TTC_ADDR_RELOAD_LOW) && !capt_ev) begin
				rl_lo_d = sfr_wdata;
			end
			if (sel(sfr_addr, `TTC_ADDR_RELOAD_HIGH) && !capt_ev) begin
				rl_hi_d = sfr_wdata;
			end
			if (sel(sfr_addr, `TTC_ADDR_COUNT_LOW)) begin
				cnt_lo_d = sfr_wdata;
			end
			if (sel(sfr_addr, `TTC_ADDR_COUNT_HIGH)) begin
				cnt_hi_d = sfr_wdata;
			end
		end
		// Flags are only ever set here, never cleared by hardware.
		if (hi_ovf || capt_ev) begin
			ctrl_d[`TTC_BIT_HIGH_FLAG] = 1'b1; // R2 R3 R6 R13
		end
		if (lo_ovf) begin
			ctrl_d[`TTC_BIT_LOW_FLAG] = 1'b1; // R5 R6
		end
	end

	// State registers, all zero after reset.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q   <= `TTC_CONTROL_RESET; // R14
			rl_lo_q  <= `TTC_BYTE_RESET;
			rl_hi_q  <= `TTC_BYTE_RESET;
			cnt_lo_q <= `TTC_BYTE_RESET;
			cnt_hi_q <= `TTC_BYTE_RESET;
		end else begin
			ctrl_q   <= ctrl_d;
			rl_lo_q  <= rl_lo_d;
			rl_hi_q  <= rl_hi_d;
			cnt_lo_q <= cnt_lo_d;
			cnt_hi_q <= cnt_hi_d;
		end
	end

	// Read data is registered one cycle after the strobe; unmapped addresses read zero.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= 8'h00;
		end else if (sfr_rd) begin
			if (!page_ok) begin
				rdata_q <= 8'h00;
			end else if (sel(sfr_addr, `TTC_ADDR_CONTROL)) begin
				rdata_q <= ctrl_q; // R1
			end else if (sel(sfr_addr, `TTC_ADDR_RELOAD_LOW)) begin
				rdata_q <= rl_lo_q;
			end else if (sel(sfr_addr, `TTC_ADDR_RELOAD_HIGH)) begin
				rdata_q <= rl_hi_q;
			end else if (sel(sfr_addr, `TTC_ADDR_COUNT_LOW)) begin
				rdata_q <= cnt_lo_q;
			end else if (sel(sfr_addr, `TTC_ADDR_COUNT_HIGH)) begin
				rdata_q <= cnt_hi_q;
			end else begin
				rdata_q <= 8'h00;
			end
		end
	end

	assign sfr_rdata = rdata_q;

	// Request is a level that stays up until software clears the flag or the enable drops.
	assign irq = timer_int_enable & (ctrl_q[`TTC_BIT_HIGH_FLAG] |
		(ctrl_q[`TTC_BIT_LOW_IE] & ctrl_q[`TTC_BIT_LOW_FLAG])); // R4 R7

endmodule

//--- src/ttc_consts.vh
// Constants for the timer three control block: addresses, fields, resets and divider counts.
`ifndef TTC_CONSTS_VH
`define TTC_CONSTS_VH

`define TTC_SFR_PAGE          8'h00
`define TTC_ADDR_CONTROL      8'h91
`define TTC_ADDR_RELOAD_LOW   8'h92
`define TTC_ADDR_RELOAD_HIGH  8'h93
`define TTC_ADDR_COUNT_LOW    8'h94
`define TTC_ADDR_COUNT_HIGH   8'h95

`define TTC_BIT_HIGH_FLAG     7
`define TTC_BIT_LOW_FLAG      6
`define TTC_BIT_LOW_IE        5
`define TTC_BIT_CAPTURE       4
`define TTC_BIT_SPLIT         3
`define TTC_BIT_RUN           2
`define TTC_BIT_CLKSEL_HI     1
`define TTC_BIT_CLKSEL_LO     0

`define TTC_CONTROL_RESET     8'h00
`define TTC_BYTE_RESET        8'h00
`define TTC_BYTE_MAX          8'hFF

`define TTC_CLKSEL_DIV12      2'h0
`define TTC_CLKSEL_OSC        2'h1
`define TTC_CLKSEL_CMP        2'h3

`define TTC_SYS_DIV           12
`define TTC_OSC_DIV           8

`endif

//--- src/ttc_sync.v
// Three-stage input synchroniser whose output follows once the last two stages agree.
`timescale 1ns/1ps

module ttc_sync (
	input  wire clk,
	input  wire rstn,
	input  wire din,
	output wire dout
);

	reg s1_q;
	reg s2_q;
	reg s3_q;
	reg out_q;

	// The first stage feeds only the second; the agreement test filters a single odd sample.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_q  <= 1'b0;
			s2_q  <= 1'b0;
			s3_q  <= 1'b0;
			out_q <= 1'b0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				out_q <= s3_q;
			end
		end
	end

	assign dout = out_q;

endmodule

//--- tb/ttc_checker.sv
// Checker for the timer three control block, bound to its ports.
`timescale 1ns/1ps
module ttc_checker (
	input wire       clk,
	input wire       rstn,
	input wire [7:0] sfr_page,
	input wire [7:0] sfr_addr,
	input wire       sfr_wr,
	input wire       sfr_rd,
	input wire [7:0] sfr_wdata,
	input wire [7:0] sfr_rdata,
	input wire       timer_int_enable,
	input wire       upper_sys_clock_sel,
	input wire       lower_sys_clock_sel,
	input wire       comparator_in,
	input wire       ext_osc_in,
	input wire       irq
);
	// Decoded page-zero accesses.
	wire       rd_ok  = sfr_rd && sfr_page == 8'h00 && !sfr_wr;
	wire       wr_ctl = sfr_wr && sfr_page == 8'h00 && sfr_addr == 8'h91;
	wire       wr_cnt = sfr_wr && sfr_page == 8'h00 && sfr_addr == 8'h94;
	reg  [5:0] ctl_q;
	// Shadow of the software-only bits; flags are left out because hardware sets them.
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			ctl_q <= 6'h00;
		else if (wr_ctl)
			ctl_q <= sfr_wdata[5:0];
	end
	reset_quiet_a: assert property (@(posedge clk) !rstn |-> sfr_rdata == 8'h00 && !irq)
		else $error("outputs busy in reset");
	irq_gate_a: assert property (@(posedge clk) disable iff (!rstn)
		!timer_int_enable |-> !irq) else $error("irq while disabled");
	unmapped_zero_a: assert property (@(posedge clk) disable iff (!rstn)
		sfr_rd && (sfr_page != 8'h00 || sfr_addr < 8'h91 || sfr_addr > 8'h95)
		|=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
	ctl_rw_a: assert property (@(posedge clk) disable iff (!rstn)
		wr_ctl ##1 !sfr_wr ##1 rd_ok && sfr_addr == 8'h91
		|=> sfr_rdata[5:0] == $past(sfr_wdata[5:0], 3)) else $error("control readback");
	cnt_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		wr_cnt && ctl_q[4:2] == 3'h0 ##1 !sfr_wr ##1 rd_ok && sfr_addr == 8'h94
		|=> sfr_rdata == $past(sfr_wdata, 3)) else $error("stopped count moved");
	flag_set_a: assert property (@(posedge clk) disable iff (!rstn)
		wr_ctl && sfr_wdata[7] && timer_int_enable ##1 timer_int_enable |-> irq)
		else $error("set flag gave no irq");
	low_irq_a: assert property (@(posedge clk) disable iff (!rstn)
		wr_ctl && sfr_wdata[6] && sfr_wdata[5] ##1 timer_int_enable |-> irq)
		else $error("low flag gave no irq");
	flag_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		$fell(irq) |-> !timer_int_enable || $past(wr_ctl)) else $error("flag self-cleared");
endmodule

bind ttc_control ttc_checker u_chk (.clk(clk), .rstn(rstn), .sfr_page(sfr_page),
	.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
	.sfr_rdata(sfr_rdata), .timer_int_enable(timer_int_enable), .irq(irq),
	.upper_sys_clock_sel(upper_sys_clock_sel), .lower_sys_clock_sel(lower_sys_clock_sel),
	.comparator_in(comparator_in), .ext_osc_in(ext_osc_in));

//--- tb/tb_top.sv
// Self-checking bench for the timer three control block.
`timescale 1ns/1ps
module tb_top;
	reg         clk, rstn, wr, rd, tie, usel, lsel, cmp, osc;
	reg  [7:0]  pg, ad, wd, d;
	reg  [15:0] rnd;
	wire [7:0]  rdata;
	wire        irq;
	integer     errors, check_count, i;
	ttc_control u_dut (.clk(clk), .rstn(rstn), .sfr_page(pg), .sfr_addr(ad), .sfr_wr(wr),
		.sfr_rd(rd), .sfr_wdata(wd), .sfr_rdata(rdata), .timer_int_enable(tie),
		.upper_sys_clock_sel(usel), .lower_sys_clock_sel(lsel), .comparator_in(cmp),
		.ext_osc_in(osc), .irq(irq));
	// Galois shift register; fixed start keeps runs repeatable.
	function [15:0] nxt(input [15:0] s);
		nxt = (s >> 1) ^ (s[0] ? 16'hb400 : 16'h0000);
	endfunction
	// Expected request line for a given control value.
	function [7:0] exp_irq(input [7:0] c);
		exp_irq = {7'h00, tie & (c[7] | (c[5] & c[6]))};
	endfunction
	task chk(input [7:0] g, input [7:0] e);
		begin
			check_count = check_count + 1;
			if (g !== e) begin
				errors = errors + 1;
				$display("wrong value at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask
	// One access; read data is registered, so it is compared a cycle later.
	task bus(input [7:0] p, input [7:0] a, input w, input [7:0] v);
		begin
			@(negedge clk);
			pg = p;
			ad = a;
			wr = w;
			rd = !w;
			wd = v;
			@(negedge clk);
			wr = 0;
			rd = 0;
			rnd = nxt(rnd);
			if (!w)
				chk(rdata, v);
		end
	endtask
	// Slow pulses on the oscillator pin, or the comparator pin when on_osc is low.
	task pulse(input on_osc, input [7:0] n);
		integer k;
		begin
			for (k = 0; k < n; k = k + 1) begin
				{osc, cmp} = on_osc ? 2'b10 : 2'b01;
				repeat (4) @(negedge clk);
				{osc, cmp} = 2'b00;
				repeat (4) @(negedge clk);
			end
		end
	endtask
	task summarize;
		begin
			$display("errors %0d checks %0d", errors, check_count);
			if (errors == 0 && check_count > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	// A hang is cut short well beyond the few hundred cycles the tests need.
	initial begin
		repeat (3000) @(posedge clk);
		errors = errors + 1;
		summarize;
	end
	initial begin
		{rstn, wr, rd, tie, usel, lsel, cmp, osc} = 8'h00;
		{pg, ad, wd} = 24'h00_0000;
		rnd = 16'hbefd;
		errors = 0;
		check_count = 0;
		repeat (8) @(posedge clk);
		@(negedge clk);
		rstn = 1;
		for (i = 8'h91; i <= 8'h95; i = i + 1)
			bus(8'h00, i[7:0], 0, 8'h00);
		// Off-page and unmapped places read as zero and an off-page write is ignored.
		bus(8'h01, 8'h91, 1, 8'hff);
		bus(8'h01, 8'h91, 0, 8'h00);
		bus(8'h00, 8'h90, 0, 8'h00);
		bus(8'h00, 8'h91, 0, 8'h00);
		// Clock select 10 gives no ticks, so random control values must read back whole.
		for (i = 0; i < 24; i = i + 1) begin
			cmp = rnd[3];
			osc = rnd[4];
			d = (rnd[7:0] & 8'hec) | 8'h02;
			tie = rnd[9];
			bus(8'h00, 8'h91, 1, d);
			bus(8'h00, 8'h91, 0, d);
			chk(irq, exp_irq(d));
		end
		{cmp, osc} = 2'b00;
		bus(8'h00, 8'h91, 1, 8'h00);
		lsel = 1;
		usel = 1;
		tie = 1;
		bus(8'h00, 8'h94, 1, 8'hf0);
		bus(8'h00, 8'h94, 0, 8'hf0);
		bus(8'h00, 8'h95, 1, 8'hff);
		bus(8'h00, 8'h93, 1, 8'h12);
		bus(8'h00, 8'h92, 1, 8'h34);
		// Sixteen-bit run from 0xfff0 wraps and reloads 0x1234.
		bus(8'h00, 8'h91, 1, 8'h04);
		repeat (40) @(negedge clk);
		bus(8'h00, 8'h91, 0, 8'hc4);
		bus(8'h00, 8'h95, 0, 8'h12);
		chk(irq, 8'h01);
		bus(8'h00, 8'h91, 1, 8'h00);
		bus(8'h00, 8'h91, 0, 8'h00);
		// Split with run clear: only the low byte moves.
		bus(8'h00, 8'h95, 1, 8'hf0);
		bus(8'h00, 8'h94, 1, 8'hf0);
		bus(8'h00, 8'h92, 1, 8'h80);
		bus(8'h00, 8'h91, 1, 8'h08);
		repeat (40) @(negedge clk);
		bus(8'h00, 8'h91, 0, 8'h48);
		bus(8'h00, 8'h95, 0, 8'hf0);
		chk(irq, 8'h00);
		bus(8'h00, 8'h91, 1, 8'h28);
		chk(irq, 8'h00);
		repeat (130) @(negedge clk);
		chk(irq, 8'h01);
		// Sixteen oscillator rises give two ticks whatever the prescaler phase.
		lsel = 0;
		usel = 0;
		bus(8'h00, 8'h91, 1, 8'h00);
		bus(8'h00, 8'h94, 1, 8'h10);
		bus(8'h00, 8'h95, 1, 8'h00);
		bus(8'h00, 8'h91, 1, 8'h05);
		pulse(1, 16);
		bus(8'h00, 8'h94, 0, 8'h12);
		bus(8'h00, 8'h91, 1, 8'h07);
		pulse(0, 3);
		bus(8'h00, 8'h94, 0, 8'h15);
		// Capture with the counter stopped, so the copied value is known.
		bus(8'h00, 8'h91, 1, 8'h10);
		bus(8'h00, 8'h95, 1, 8'ha5);
		bus(8'h00, 8'h94, 1, 8'h5a);
		pulse(0, 1);
		bus(8'h00, 8'h92, 0, 8'h5a);
		bus(8'h00, 8'h93, 0, 8'ha5);
		bus(8'h00, 8'h91, 0, 8'h90);
		chk(irq, 8'h01);
		bus(8'h00, 8'h91, 1, 8'h13);
		bus(8'h00, 8'h94, 1, 8'h3c);
		pulse(1, 8);
		bus(8'h00, 8'h92, 0, 8'h3c);
		bus(8'h00, 8'h91, 0, 8'h93);
		// Split with run set: the upper byte counts every clock and reloads 0x40 after 0xff.
		bus(8'h00, 8'h91, 1, 8'h00);
		usel = 1;
		bus(8'h00, 8'h93, 1, 8'h40);
		bus(8'h00, 8'h95, 1, 8'hf8);
		bus(8'h00, 8'h91, 1, 8'h0c);
		repeat (20) @(negedge clk);
		bus(8'h00, 8'h91, 0, 8'h8c);
		bus(8'h00, 8'h91, 1, 8'h08);
		bus(8'h00, 8'h95, 0, 8'h50);
		// A lone low-byte roll in 16-bit mode carries upward instead of reloading.
		bus(8'h00, 8'h91, 1, 8'h00);
		lsel = 1;
		bus(8'h00, 8'h94, 1, 8'hff);
		bus(8'h00, 8'h95, 1, 8'h00);
		bus(8'h00, 8'h92, 1, 8'h77);
		bus(8'h00, 8'h91, 1, 8'h04);
		bus(8'h00, 8'h91, 1, 8'h00);
		bus(8'h00, 8'h94, 0, 8'h01);
		bus(8'h00, 8'h95, 0, 8'h01);
		summarize;
	end
endmodule
